// *** src/six_bit_io_port.sv ***
// Six-bit general-purpose I/O port with write-only direction register.
// Assumes the core gives one-cycle strobes synchronous to SYS_CLK_IN,
// and that pin levels arrive already synchronous to that clock.
//
// Notes on behaviour
// - A port read returns pin levels, not latches, in either direction.
// - A reset on RESET_N_IN makes every pin an input with its driver off.
// - Port register is eight bits; only the low six reach pins.
// - Bits seven and six read as zero.
// - Pin three is input only and never drives.
// - Pins given to an alternate function read as zero.
// - Pins zero, one, three share one pull-up and one wake setting.
// - Master reset on pin three forces pull-up on and wake off.
// - Direction changes only by the direction-load strobe, from core data.
// - Direction one floats the pin; zero drives it from its latch.
// - Direction register is write-only and resets to all ones.
// - Timer clock-source select forces the timer clock pin to input.
// - Latches are cleared only on power-on, kept over other resets.
// - Latches hold until the port register is written again.
// - Each pin, pin three included, has its own direction bit.
`include "six_bit_io_port_defines.svh"
`timescale 1ns/10ps

module six_bit_io_port (
    // Clock and resets
    input  wire logic                            SYS_CLK_IN,
    input  wire logic                            RESET_N_IN,
    input  wire logic                            POR_N_IN,
    // Port register access from the core
    input  wire logic                            PORT_WR_IN,
    input  wire six_bit_io_port_pkg::port_byte_t PORT_WDATA_IN,
    input  wire logic                            PORT_RD_IN,
    output six_bit_io_port_pkg::port_byte_t      PORT_RDATA_OUT,
    // Direction-load instruction
    input  wire logic                            DIR_LOAD_IN,
    input  wire six_bit_io_port_pkg::port_byte_t DIR_WDATA_IN,
    // Configuration
    input  wire six_bit_io_port_pkg::pin_vec_t   ALT_FUNC_IN,
    input  wire logic                            MASTER_RESET_INPUT_EN_IN,
    input  wire logic                            PULLUP_EN_IN,
    input  wire logic                            WAKE_EN_IN,
    input  wire logic                            TIMER_CLK_SEL_IN,
    // Pins
    input  wire six_bit_io_port_pkg::pin_vec_t   PIN_IN,
    output six_bit_io_port_pkg::pin_vec_t        PIN_OUT,
    output six_bit_io_port_pkg::pin_vec_t        PIN_OE_N_OUT,
    output six_bit_io_port_pkg::pin_vec_t        PULLUP_OUT,
    output logic                                 WAKE_OUT
);
    import six_bit_io_port_pkg::*;

    // --------------------------------------------------------------------
    // Internal signals
    // --------------------------------------------------------------------
    pin_vec_t   dir_bits;
    pin_vec_t   latch_bits;
    pin_vec_t   force_input;
    pin_vec_t   alt_mask;
    pin_vec_t   wake_mask;
    pin_vec_t   pull_force;
    port_byte_t read_nxt;
    port_byte_t rdata_r;
    pin_vec_t   snap_r;
    logic       armed_r;
    logic       wake_r;
    logic       wake_nxt;

    // --------------------------------------------------------------------
    // Overrides from configuration
    // --------------------------------------------------------------------
    // Timer clock pin turns input when the timer counts external edges.
    assign force_input = TIMER_CLK_SEL_IN ? pin_vec_t'(`TIMER_CLK_MASK)
                                          : '0;

    // Master reset use of pin three is an alternate function of that pin.
    assign alt_mask = ALT_FUNC_IN |
                      (MASTER_RESET_INPUT_EN_IN ? pin_vec_t'(`INPUT_ONLY_MASK)
                                  : '0);

    // One shared enable covers all three capable pins.
    assign pull_force = MASTER_RESET_INPUT_EN_IN ? pin_vec_t'(`INPUT_ONLY_MASK) : '0;
    assign PULLUP_OUT = pin_vec_t'(`WAKE_PULL_MASK) &
                        ((PULLUP_EN_IN ? '1 : '0) |
                         pull_force);

    assign wake_mask = pin_vec_t'(`WAKE_PULL_MASK) &
                       ~pull_force;

    // --------------------------------------------------------------------
    // Per-pin direction, latch and driver
    // --------------------------------------------------------------------
    // Every pin owns its direction bit; pin three is built input only.
    genvar gi;
    generate
        for (gi = 0; gi < `PORT_PIN_COUNT; gi = gi + 1) begin : g_pin
            io_pin_cell #(
                .INPUT_ONLY     (gi == `INPUT_ONLY_PIN)
            ) u_cell (
                .clk_in         (SYS_CLK_IN),
                .reset_n_in     (RESET_N_IN),
                .por_n_in       (POR_N_IN),
                .latch_wr_in    (PORT_WR_IN),
                .latch_data_in  (PORT_WDATA_IN[gi]),
                .dir_load_in    (DIR_LOAD_IN),
                .dir_data_in    (DIR_WDATA_IN[gi]),
                .force_input_in (force_input[gi]),
                .dir_out        (dir_bits[gi]),
                .latch_out      (latch_bits[gi]),
                .pin_out        (PIN_OUT[gi]),
                .pin_oe_n_out   (PIN_OE_N_OUT[gi])
            );
        end
    endgenerate

    // --------------------------------------------------------------------
    // Port read
    // --------------------------------------------------------------------
    // Reads sample the pins themselves, so an input is seen only while
    // the outside source still holds it.
    assign read_nxt = {`UNIMPL_READ_BITS,
                       PIN_IN & ~alt_mask};

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rdata_r <= `READ_DATA_RESET;
        end else if (PORT_RD_IN) begin
            rdata_r <= read_nxt;
        end
    end

    assign PORT_RDATA_OUT = rdata_r;

    // --------------------------------------------------------------------
    // Wake on change
    // --------------------------------------------------------------------
    // The reference level is the one seen at the last port read; no
    // wake is raised before the first read has armed the comparison.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            snap_r  <= '0;
            armed_r <= 1'b0;
        end else if (PORT_RD_IN) begin
            snap_r  <= PIN_IN;
            armed_r <= 1'b1;
        end
    end

    assign wake_nxt = armed_r & WAKE_EN_IN &
                      (|((PIN_IN ^ snap_r) & wake_mask));

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_nxt;
        end
    end

    assign WAKE_OUT = wake_r;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN || !POR_N_IN);

    read_pin_level_a: assert property (
        PORT_RD_IN && ALT_FUNC_IN == '0 && !MASTER_RESET_INPUT_EN_IN
        |=> PORT_RDATA_OUT[`PORT_PIN_COUNT-1:0] == $past(PIN_IN))
        else $error("Port read does not show the pin levels.");

    read_alt_zero_a: assert property (
        PORT_RD_IN
        |=> (PORT_RDATA_OUT[`PORT_PIN_COUNT-1:0] & $past(ALT_FUNC_IN)) == '0)
        else $error("Alternate function pin does not read as zero.");

    upper_bits_zero_a: assert property (
        PORT_RDATA_OUT[`PORT_REG_WIDTH-1:`PORT_PIN_COUNT] == '0)
        else $error("Unimplemented port bits read as one.");

    read_hold_a: assert property (
        !PORT_RD_IN |=> $stable(PORT_RDATA_OUT))
        else $error("Read data changed without a port read.");

    reset_input_a: assert property (
        $rose(RESET_N_IN) |-> PIN_OE_N_OUT == '1)
        else $error("A pin drives right after reset.");

    input_only_a: assert property (
        PIN_OE_N_OUT[`INPUT_ONLY_PIN])
        else $error("Input-only pin is driving.");

    dir_load_a: assert property (
        DIR_LOAD_IN
        |=> dir_bits == $past(DIR_WDATA_IN[`PORT_PIN_COUNT-1:0]))
        else $error("Direction load did not copy core data.");

    dir_hold_a: assert property (
        !DIR_LOAD_IN |=> $stable(dir_bits))
        else $error("Direction changed without a direction load.");

    drive_latch_a: assert property (
        !dir_bits[0] |-> !PIN_OE_N_OUT[0] && PIN_OUT[0] == latch_bits[0])
        else $error("Output pin does not drive its latch.");

    float_input_a: assert property (
        dir_bits[1] |-> PIN_OE_N_OUT[1])
        else $error("Pin set as input is driving.");

    timer_input_a: assert property (
        TIMER_CLK_SEL_IN |-> PIN_OE_N_OUT[`TIMER_CLK_PIN])
        else $error("Timer clock pin drives while selected.");

    latch_write_a: assert property (
        PORT_WR_IN
        |=> latch_bits == $past(PORT_WDATA_IN[`PORT_PIN_COUNT-1:0]))
        else $error("Port write did not load every latch.");

    latch_hold_a: assert property (
        !PORT_WR_IN |=> $stable(latch_bits))
        else $error("Latch changed without a port write.");

    master_reset_input_pull_a: assert property (
        MASTER_RESET_INPUT_EN_IN |-> PULLUP_OUT[`INPUT_ONLY_PIN] &&
                       !wake_mask[`INPUT_ONLY_PIN])
        else $error("Master reset pin lacks pull-up or still wakes.");

    pull_common_a: assert property (
        !MASTER_RESET_INPUT_EN_IN |-> PULLUP_OUT ==
            (PULLUP_EN_IN ? pin_vec_t'(`WAKE_PULL_MASK) : pin_vec_t'('0)))
        else $error("Pull-ups do not follow the common setting.");

    wake_off_a: assert property (
        !WAKE_EN_IN |=> !WAKE_OUT)
        else $error("Wake raised while wake on change is off.");

endmodule

// *** common/six_bit_io_port_defines.svh ***
// Constants of the six-bit I/O port: widths, pin positions, reset values.
// Assumes nothing; included by the package and the design files.
`ifndef SIX_BIT_IO_PORT_DEFINES_SVH
`define SIX_BIT_IO_PORT_DEFINES_SVH

// ------------------------------------------------------------------------
// Widths
// ------------------------------------------------------------------------
`define PORT_REG_WIDTH     8
`define PORT_PIN_COUNT     6

// ------------------------------------------------------------------------
// Pin positions and masks
// ------------------------------------------------------------------------
`define INPUT_ONLY_PIN     3
`define TIMER_CLK_PIN      2
`define WAKE_PULL_MASK     6'h0b
`define INPUT_ONLY_MASK    6'h08
`define TIMER_CLK_MASK     6'h04
`define UNIMPL_READ_BITS   2'h0

// ------------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------------
`define DIRECTION_RESET    6'h3f
`define LATCH_POR_VALUE    6'h00
`define READ_DATA_RESET    8'h00

`endif

// *** common/six_bit_io_port_pkg.sv ***
// Types shared by the six-bit I/O port design files.
// Assumes the constants header sits beside it on the include path.
`include "six_bit_io_port_defines.svh"

package six_bit_io_port_pkg;

    typedef logic [`PORT_PIN_COUNT-1:0] pin_vec_t;
    typedef logic [`PORT_REG_WIDTH-1:0] port_byte_t;

    // Meaning of one direction bit.
    typedef enum logic {
        PIN_DRIVE = 1'b0,
        PIN_FLOAT = 1'b1
    } pin_mode_t;

endpackage

// *** src/io_pin_cell.sv ***
// One port pin: its direction bit, its output latch and its driver.
// Assumes strobes and data come synchronous to the system clock.
`include "six_bit_io_port_defines.svh"
`timescale 1ns/10ps

module io_pin_cell #(
    parameter bit INPUT_ONLY = 1'b0
) (
    // Clock and resets
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic por_n_in,
    // Core writes
    input  wire logic latch_wr_in,
    input  wire logic latch_data_in,
    input  wire logic dir_load_in,
    input  wire logic dir_data_in,
    // Overrides
    input  wire logic force_input_in,
    // Pin side
    output logic      dir_out,
    output logic      latch_out,
    output logic      pin_out,
    output logic      pin_oe_n_out
);
    import six_bit_io_port_pkg::*;

    logic dir_r;
    logic latch_r;

    // Direction is set by reset_n_in only, not by a power-on reset alone.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_r <= 1'b1;
        end else if (dir_load_in) begin
            dir_r <= dir_data_in;
        end
    end

    // The latch only clears on power-on; other resets leave it alone.
    always_ff @(posedge clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            latch_r <= 1'b0;
        end else if (latch_wr_in) begin
            latch_r <= latch_data_in;
        end
    end

    assign dir_out   = dir_r;
    assign latch_out = latch_r;
    assign pin_out   = latch_r;
    assign pin_oe_n_out = INPUT_ONLY | force_input_in |
                          (pin_mode_t'(dir_r) == PIN_FLOAT);

endmodule

// *** verif/pin_wire_model.sv ***
// Far-side model of the six port pins: external sources and wire levels.
// Assumes the bench changes the external sources just after a clock edge.
`timescale 1ns/10ps

module pin_wire_model (
    // Design side
    input  wire six_bit_io_port_pkg::pin_vec_t pin_out_in,
    input  wire six_bit_io_port_pkg::pin_vec_t pin_oe_n_in,
    input  wire six_bit_io_port_pkg::pin_vec_t pullup_in,
    // External sources
    input  wire six_bit_io_port_pkg::pin_vec_t ext_en_in,
    input  wire six_bit_io_port_pkg::pin_vec_t ext_val_in,
    // Resolved wire levels
    output six_bit_io_port_pkg::pin_vec_t      level_out
);
    import six_bit_io_port_pkg::*;

    // -------------------------------------------------------------------
    // Wire resolution
    // -------------------------------------------------------------------
    // A source level stays as given until the bench changes it, so it is
    // held across the read that samples it. A pin nobody drives and with
    // no pull-up shows the inverse of the source value, never a stale one.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pin_oe_n_in[i])
                level_out[i] = pin_out_in[i];
            else if (ext_en_in[i])
                level_out[i] = ext_val_in[i];
            else if (pullup_in[i])
                level_out[i] = 1'b1;
            else
                level_out[i] = ~ext_val_in[i];
        end
    end
endmodule

// *** verif/six_bit_io_port_bench.sv ***
// Self-checking bench of the six-bit I/O port.
// Assumes the design files and the pin model are compiled before it.
`timescale 1ns/10ps

module six_bit_io_port_bench;
    import six_bit_io_port_pkg::*;

    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    logic       clk;
    logic       rst_n;
    logic       por_n;
    logic       wr;
    port_byte_t wdata;
    logic       rd;
    port_byte_t rdata;
    logic       dload;
    port_byte_t dwdata;
    pin_vec_t   alt;
    logic       master_reset_input;
    logic       pu;
    logic       wk;
    logic       tsel;
    pin_vec_t   pin_in;
    pin_vec_t   pin_out;
    pin_vec_t   oe_n;
    pin_vec_t   pull;
    logic       wake;
    pin_vec_t   ext_en;
    pin_vec_t   ext_val;
    int         n_mismatch;
    int         num_checks;

    six_bit_io_port u_dut (
        .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .POR_N_IN(por_n),
        .PORT_WR_IN(wr), .PORT_WDATA_IN(wdata), .PORT_RD_IN(rd),
        .PORT_RDATA_OUT(rdata), .DIR_LOAD_IN(dload), .DIR_WDATA_IN(dwdata),
        .ALT_FUNC_IN(alt), .MASTER_RESET_INPUT_EN_IN(master_reset_input), .PULLUP_EN_IN(pu),
        .WAKE_EN_IN(wk), .TIMER_CLK_SEL_IN(tsel), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N_OUT(oe_n), .PULLUP_OUT(pull),
        .WAKE_OUT(wake)
    );

    pin_wire_model u_pins (
        .pin_out_in(pin_out), .pin_oe_n_in(oe_n), .pullup_in(pull),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in)
    );

    always #5 clk = ~clk;

    // -------------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------------
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input port_byte_t got, input port_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pwr(input port_byte_t v);
        wdata = v;
        wr = 1'b1;
        step();
        wr = 1'b0;
    endtask

    task automatic prd(input port_byte_t exp);
        rd = 1'b1;
        step();
        rd = 1'b0;
        chk(rdata, exp);
    endtask

    task automatic dld(input port_byte_t v);
        dwdata = v;
        dload = 1'b1;
        step();
        dload = 1'b0;
    endtask

    task automatic rst(input logic power_on);
        rst_n = 1'b0;
        por_n = ~power_on;
        repeat (20) step();
        rst_n = 1'b1;
        por_n = 1'b1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------
    initial begin
        {clk, wr, rd, dload, master_reset_input, pu, wk, tsel} = '0;
        {rst_n, por_n} = 2'b00;
        {wdata, dwdata, alt, ext_en, ext_val} = '0;
        n_mismatch = 0;
        num_checks = 0;
        rst(1'b1);
        chk({2'h0, oe_n}, 8'h3f);
        chk(rdata, 8'h00);
        chk({2'h0, pin_out}, 8'h00);
        $display("reset test done");
        pwr(8'hff);
        chk({2'h0, pin_out}, 8'h3f);
        ext_en = 6'h3f;
        ext_val = 6'h2a;
        prd(8'h2a);
        dld(8'h00);
        chk({2'h0, oe_n}, 8'h08);
        prd(8'h3f);
        ext_val = 6'h00;
        prd(8'h37);
        pwr(8'hc5);
        chk({2'h0, pin_out}, 8'h05);
        prd(8'h05);
        dwdata = 8'h3f;
        step();
        chk({2'h0, oe_n}, 8'h08);
        for (int i = 0; i < 6; i++) begin
            dld(8'hff ^ (8'h01 << i));
            chk({2'h0, oe_n}, (8'h3f & ~(8'h01 << i)) | 8'h08);
        end
        dld(8'h00);
        tsel = 1'b1;
        step();
        chk({2'h0, oe_n}, 8'h0c);
        tsel = 1'b0;
        $display("direction test done");
        dld(8'h3f);
        ext_val = 6'h3f;
        alt = 6'h22;
        prd(8'h1d);
        alt = 6'h00;
        master_reset_input = 1'b1;
        step();
        chk({2'h0, pull}, 8'h08);
        wk = 1'b1;
        prd(8'h37);
        ext_val = 6'h37;
        repeat (2) step();
        chk({7'h0, wake}, 8'h00);
        master_reset_input = 1'b0;
        prd(8'h37);
        ext_val = 6'h27;
        repeat (2) step();
        chk({7'h0, wake}, 8'h00);
        ext_val = 6'h2f;
        repeat (2) step();
        chk({7'h0, wake}, 8'h01);
        prd(8'h2f);
        step();
        chk({7'h0, wake}, 8'h00);
        wk = 1'b0;
        pu = 1'b1;
        step();
        chk({2'h0, pull}, 8'h0b);
        pu = 1'b0;
        $display("config test done");
        dld(8'h00);
        pwr(8'h1a);
        rst(1'b0);
        chk({2'h0, pin_out}, 8'h1a);
        chk({2'h0, oe_n}, 8'h3f);
        chk(rdata, 8'h00);
        rst(1'b1);
        chk({2'h0, pin_out}, 8'h00);
        $display("second reset test done");
        give_verdict();
    end

    initial begin
        #50000;
        n_mismatch++;
        give_verdict();
    end
endmodule
